// File: mie_add_if.sv
// Carrier between the core and its adder.
// Assumes one core drives the operands and one adder answers.
`timescale 1ns/1ps
interface mie_add_if;
  logic [7:0] a;
  logic [7:0] b;
  logic cin;
  logic [7:0] sum;
  logic c;
  logic dc;
  logic z;
  modport core (output a, output b, output cin,
                input sum, input c, input dc, input z);
  modport alu (input a, input b, input cin,
               output sum, output c, output dc, output z);
endinterface

// File: mie_adder.sv
// Eight-bit adder with carry in, carry, nibble carry and zero outputs.
// Assumes operands are stable within the cycle; purely combinational.
`timescale 1ns/1ps
module mie_adder (
  // Operands and results
  mie_add_if.alu bus
);
  import mie_pkg::*;

  logic [4:0] lo;
  logic [8:0] full;

  assign lo = {1'b0, bus.a[3:0]} + {1'b0, bus.b[3:0]} + {4'h0, bus.cin};
  assign full = {1'b0, bus.a} + {1'b0, bus.b} + {8'h00, bus.cin};
  assign bus.sum = full[7:0];
  assign bus.c = full[8];
  assign bus.dc = lo[4];
  assign bus.z = (full[7:0] == 8'h00);
endmodule // mie_adder

// File: mie_core.sv
// Instruction decode and execute core with a Wishbone register port.
// Assumes program memory answers pm_data_i in the cycle pm_addr_o is shown.
//
// How it works
// - Bit test skips next when bit matches.
// - Increment/decrement, write destination, skip on zero.
// - Sleep halts core and clears power-down flag.
// - Power-down flag is one after reset, watchdog kick.
// - Time-out flag one after reset, kick, sleep.
// - Watchdog timeout clears the time-out flag.
// - Interrupt return pops PC, enables interrupts, two cycles.
// - Returns pop PC; literal form loads accumulator.
// - Indirect call/jump target low byte from accumulator, two cycles.
// - Subroutine return resumes after caller, two cycles.
// - F-page moves accept addresses five to fifteen.
// - S-page moves address all sixteen registers.
// - R-page operand addresses sixty-four locations.
// - Destination bit: zero accumulator, one register.
// - Carry set on add carry, no borrow.
// - Register adds update flags, write destination.
// - Immediate add leaves sum in accumulator.
// - Immediate add with carry into accumulator.
// - Table read two cycles, high byte buffered.
//
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module mie_core (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Program memory
  output logic [9:0] pm_addr_o,
  input wire logic [13:0] pm_data_i,
  // System
  input wire logic wdt_timeout_i,
  input wire logic wake_i,
  output logic wdt_clear_o,
  output logic halt_o,
  output logic irq_enable_o
);
  import mie_pkg::*;

  // ************************************************************
  // Decode
  // ************************************************************
  mie_regs_t st_ff;
  mie_regs_t nxt_st;
  mie_op_t op;
  logic [5:0] ridx;
  logic [2:0] bsel;
  logic [3:0] pidx;
  logic [7:0] imm;
  logic [7:0] rval;
  logic [7:0] res;
  logic [9:0] pc_inc;
  logic [9:0] tbl_addr;
  logic [1:0] sp_dn;
  logic dsel;
  logic ex;
  logic bus_wr;
  logic [7:0] badr;
  logic [31:0] rd_word;

  assign op = mie_op_t'(pm_data_i[`MIE_OP_MSB:`MIE_OP_LSB]);
  assign ridx = pm_data_i[`MIE_R_MSB:0];
  assign bsel = pm_data_i[`MIE_BIT_MSB:`MIE_BIT_LSB];
  assign pidx = pm_data_i[3:0];
  assign imm = pm_data_i[7:0];
  assign dsel = pm_data_i[`MIE_D_BIT];
  assign rval = st_ff.rmem[ridx];
  assign pc_inc = st_ff.pc + 10'h001;
  assign sp_dn = st_ff.sp - 2'h1;
  assign tbl_addr = {st_ff.smem[`MIE_TBL_SIDX][1:0], st_ff.acc};
  // Low in reset, so no check reads the word shown at the release edge.
  assign ex = !rst_i && (st_ff.state == st_run) && st_ff.run && !st_ff.skip;
  assign badr = {wb_adr_i[7:2], 2'h0};
  assign bus_wr = st_ff.ack && wb_cyc_i && wb_stb_i && wb_we_i;

  // ************************************************************
  // Adder
  // ************************************************************
  mie_add_if add_bus ();

  assign add_bus.a = st_ff.acc;
  assign add_bus.b = (op == op_addi || op == op_adci) ? imm : rval;
  assign add_bus.cin = (op == op_adcr || op == op_adci) && st_ff.c;

  mie_adder u_add (
    .bus(add_bus)
  );

  // ************************************************************
  // Register read mux
  // ************************************************************
  always_comb
  begin
    unique case (badr)
      `MIE_OFF_STATUS: rd_word = {25'h0, st_ff.gie,
        (st_ff.state == st_halt), st_ff.to_n, st_ff.pd_n,
        st_ff.c, st_ff.dc, st_ff.z};
      `MIE_OFF_ACC: rd_word = {24'h0, st_ff.acc};
      `MIE_OFF_PC: rd_word = {22'h0, st_ff.pc};
      `MIE_OFF_CTRL: rd_word = {31'h0, st_ff.run};
      `MIE_OFF_HIBYTE: rd_word = {26'h0, st_ff.hibyte_buf};
      default: rd_word = 32'h0;
    endcase
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.kick = 1'b0;
    nxt_st.ack = wb_cyc_i && wb_stb_i && !st_ff.ack;
    if (nxt_st.ack)
    begin
      nxt_st.dat = rd_word;
    end
    res = 8'h00;
    unique case (st_ff.state)
      st_run:
      begin
        if (st_ff.run && st_ff.skip)
        begin
          // The fetched word is thrown away; only the PC moves.
          nxt_st.pc = pc_inc;
          nxt_st.skip = 1'b0;
        end
        else if (st_ff.run)
        begin
          nxt_st.pc = pc_inc;
          unique case (op)
            op_btsz:
              nxt_st.skip = !rval[bsel];
            op_btso:
              nxt_st.skip = rval[bsel];
            op_incsz, op_decsz:
            begin
              res = (op == op_incsz) ? rval + 8'h01 : rval - 8'h01;
              nxt_st.skip = (res == 8'h00);
              if (dsel)
                nxt_st.rmem[ridx] = res;
              else
                nxt_st.acc = res;
            end
            op_sleep:
            begin
              nxt_st.state = st_halt;
              nxt_st.pd_n = 1'b0;
              nxt_st.to_n = 1'b1;
            end
            op_kick:
            begin
              nxt_st.pd_n = 1'b1;
              nxt_st.to_n = 1'b1;
              nxt_st.kick = 1'b1;
            end
            op_irq_on:
              nxt_st.gie = 1'b1;
            op_irq_off:
              nxt_st.gie = 1'b0;
            op_ret, op_reti_en, op_retlit:
            begin
              nxt_st.pc = st_ff.stk[sp_dn];
              nxt_st.sp = sp_dn;
              nxt_st.state = st_busy;
              if (op == op_reti_en)
                nxt_st.gie = 1'b1;
              if (op == op_retlit)
                nxt_st.acc = imm;
            end
            op_call_indirect_accum, op_jump_indirect_accum:
            begin
              nxt_st.pc = {st_ff.pc[9:8], st_ff.acc};
              nxt_st.state = st_busy;
              if (op == op_call_indirect_accum)
              begin
                nxt_st.stk[st_ff.sp] = pc_inc;
                nxt_st.sp = st_ff.sp + 2'h1;
              end
            end
            op_fwr:
              if (pidx >= `MIE_FPAGE_MIN)
                nxt_st.fmem[pidx] = st_ff.acc;
            op_frd:
              if (pidx >= `MIE_FPAGE_MIN)
                nxt_st.acc = st_ff.fmem[pidx];
            op_swr:
              nxt_st.smem[pidx] = st_ff.acc;
            op_srd:
              nxt_st.acc = st_ff.smem[pidx];
            op_table:
            begin
              nxt_st.tbl = 1'b1;
              nxt_st.state = st_busy;
            end
            op_addr, op_adcr, op_addi, op_adci:
            begin
              nxt_st.z = add_bus.z;
              nxt_st.dc = add_bus.dc;
              nxt_st.c = add_bus.c;
              if (dsel && (op == op_addr || op == op_adcr))
                nxt_st.rmem[ridx] = add_bus.sum;
              else
                nxt_st.acc = add_bus.sum;
            end
            default:
              nxt_st.pc = pc_inc;
          endcase
        end
      end
      st_busy:
      begin
        // Second cycle: for a table read, the table word is on the bus now.
        nxt_st.state = st_run;
        if (st_ff.tbl)
        begin
          nxt_st.tbl = 1'b0;
          nxt_st.hibyte_buf = pm_data_i[13:8];
          nxt_st.acc = pm_data_i[7:0];
        end
      end
      st_halt:
        if (wake_i || wdt_timeout_i)
          nxt_st.state = st_run;
      default:
        nxt_st.state = st_run;
    endcase
    // A timeout beats a kick or sleep landing in the same cycle.
    if (wdt_timeout_i)
      nxt_st.to_n = 1'b0;
    // Bus writes land last, so software wins over an instruction.
    if (bus_wr && wb_sel_i[0])
    begin
      if (badr == `MIE_OFF_ACC)
        nxt_st.acc = wb_dat_i[7:0];
      if (badr == `MIE_OFF_CTRL)
      begin
        nxt_st.run = wb_dat_i[`MIE_CT_RUN];
        if (wb_dat_i[`MIE_CT_WAKE] && st_ff.state == st_halt)
          nxt_st.state = st_run;
      end
    end
    nxt_st.fetch = (nxt_st.tbl) ? tbl_addr : nxt_st.pc;
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_ff <= '0;
      st_ff.state <= st_run;
      st_ff.pc <= `MIE_RST_PC;
      st_ff.fetch <= `MIE_RST_PC;
      st_ff.acc <= `MIE_RST_ACC;
      st_ff.pd_n <= 1'b1;
      st_ff.to_n <= 1'b1;
      st_ff.run <= `MIE_RST_RUN;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign wb_dat_o = st_ff.dat;
  assign wb_ack_o = st_ff.ack;
  assign pm_addr_o = st_ff.fetch;
  assign wdt_clear_o = st_ff.kick;
  assign halt_o = (st_ff.state == st_halt);
  assign irq_enable_o = st_ff.gie;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_SLEEP_PD: assert property (ex && op == op_sleep && !bus_wr |=>
    halt_o && !st_ff.pd_n)
    else $error("sleep did not halt with power-down flag low");
  AST_KICK_FLAGS: assert property (ex && op == op_kick &&
    !wdt_timeout_i |=> st_ff.pd_n && st_ff.to_n && wdt_clear_o)
    else $error("kick did not raise both flags");
  AST_SLEEP_TO: assert property (ex && op == op_sleep &&
    !wdt_timeout_i |=> st_ff.to_n)
    else $error("sleep did not raise time-out flag");
  AST_TIMEOUT: assert property (wdt_timeout_i |=> !st_ff.to_n)
    else $error("timeout did not clear time-out flag");
  AST_SKIP_BIT: assert property (ex && op == op_btsz &&
    !rval[bsel] |=> st_ff.skip ##1 !st_ff.skip || !st_ff.run)
    else $error("bit test skip not taken");
  AST_INC_SKIP: assert property (ex && op == op_incsz &&
    rval == 8'hFF |=> st_ff.skip)
    else $error("increment to zero did not skip");
  AST_IRQ_RETURN: assert property (ex && op == op_reti_en |=>
    st_ff.gie && st_ff.state == st_busy &&
    st_ff.pc == $past(st_ff.stk[sp_dn]) ##1 st_ff.state == st_run)
    else $error("interrupt return wrong");
  AST_CALL_INDIRECT_ACCUM: assert property (ex && op == op_call_indirect_accum && !bus_wr |=>
    st_ff.pc[7:0] == $past(st_ff.acc) &&
    st_ff.stk[$past(st_ff.sp)] == $past(pc_inc))
    else $error("indirect call wrong target or return");
  AST_FPAGE_LOW: assert property (ex && op == op_fwr &&
    pidx < `MIE_FPAGE_MIN |=> $stable(st_ff.fmem))
    else $error("low F-page address was written");
  AST_ADD_IMM: assert property (ex && op == op_addi && !bus_wr |=>
    st_ff.acc == $past(st_ff.acc) + $past(imm))
    else $error("immediate add wrong sum");
  AST_SKIPPED_NOP: assert property (st_ff.state == st_run &&
    st_ff.run && st_ff.skip && !bus_wr && !wdt_timeout_i |=>
    $stable(st_ff.acc) && $stable(st_ff.rmem) && $stable(st_ff.c) &&
    $stable(st_ff.to_n))
    else $error("skipped instruction changed state");
  AST_TABLE: assert property (ex && op == op_table |=>
    st_ff.state == st_busy ##1 st_ff.hibyte_buf == $past(pm_data_i[13:8]))
    else $error("table read did not buffer high byte");

  COV_SKIP: cover property (ex && op == op_btso && rval[bsel]);
  COV_WAKE: cover property (halt_o ##[1:20] !halt_o);
  COV_TABLE: cover property (ex && op == op_table);
  COV_CALL_RET: cover property (ex && op == op_call_indirect_accum ##[2:20]
    ex && op == op_ret);
endmodule // mie_core

// File: mie_defines.svh
// Constants of the instruction execute block: bus map, fields, resets.
// Assumes inclusion by bare name from the package and the testbench.
`ifndef MIE_DEFINES_SVH
`define MIE_DEFINES_SVH

// ************************************************************
// Widths and sizes
// ************************************************************
`define MIE_PC_W 10
`define MIE_IW 14
`define MIE_STK_D 4
`define MIE_FPAGE_MIN 4'h5
`define MIE_TBL_SIDX 4'h0

// ************************************************************
// Register offsets on the bus (byte addresses)
// ************************************************************
`define MIE_OFF_STATUS 8'h00
`define MIE_OFF_ACC 8'h04
`define MIE_OFF_PC 8'h08
`define MIE_OFF_CTRL 8'h0C
`define MIE_OFF_HIBYTE 8'h10

// ************************************************************
// Field positions
// ************************************************************
`define MIE_ST_Z 0
`define MIE_ST_DC 1
`define MIE_ST_C 2
`define MIE_ST_PD 3
`define MIE_ST_TO 4
`define MIE_ST_HALT 5
`define MIE_ST_GIE 6
`define MIE_CT_RUN 0
`define MIE_CT_WAKE 1
`define MIE_OP_MSB 13
`define MIE_OP_LSB 9
`define MIE_BIT_MSB 8
`define MIE_BIT_LSB 6
`define MIE_D_BIT 6
`define MIE_R_MSB 5

// ************************************************************
// Reset values
// ************************************************************
`define MIE_RST_RUN 1'b1
`define MIE_RST_ACC 8'h00
`define MIE_RST_PC 10'h000

`endif

// File: mie_pkg.sv
// Types of the instruction execute block: states, opcodes, core state.
// Assumes mie_defines.svh is on the include path.
package mie_pkg;
  `include "mie_defines.svh"

  typedef enum logic [2:0] {
    st_run  = 3'h1,
    st_busy = 3'h2,
    st_halt = 3'h4
  } mie_state_t;

  typedef enum logic [4:0] {
    op_nop = 5'h00, op_btsz = 5'h01, op_btso = 5'h02, op_incsz = 5'h03,
    op_decsz = 5'h04, op_sleep = 5'h05, op_kick = 5'h06,
    op_irq_on = 5'h07, op_irq_off = 5'h08, op_ret = 5'h09,
    op_reti_en = 5'h0A, op_retlit = 5'h0B, op_call_indirect_accum = 5'h0C,
    op_jump_indirect_accum = 5'h0D, op_fwr = 5'h0E, op_frd = 5'h0F, op_swr = 5'h10,
    op_srd = 5'h11, op_table = 5'h12, op_addr = 5'h13, op_adcr = 5'h14,
    op_addi = 5'h15, op_adci = 5'h16
  } mie_op_t;

  typedef struct packed {
    mie_state_t state;
    logic [`MIE_PC_W-1:0] pc;
    logic [`MIE_PC_W-1:0] fetch;
    logic [7:0] acc;
    logic z;
    logic dc;
    logic c;
    logic pd_n;
    logic to_n;
    logic gie;
    logic skip;
    logic tbl;
    logic kick;
    logic run;
    logic ack;
    logic [31:0] dat;
    logic [5:0] hibyte_buf;
    logic [1:0] sp;
    logic [`MIE_STK_D-1:0][`MIE_PC_W-1:0] stk;
    logic [63:0][7:0] rmem;
    logic [15:0][7:0] fmem;
    logic [15:0][7:0] smem;
  } mie_regs_t;
endpackage

// File: mie_pmem_model.sv
// Program memory model for the instruction execute core.
// Assumes the bench fills the store array while the core is held or halted.
`timescale 1ns/1ps
module mie_pmem_model (
  // Fetch port
  input wire logic [9:0] addr_i,
  output logic [13:0] data_o
);
  logic [13:0] store [1024];

  // ********************
  // Read path
  // ********************
  // The core executes the word in the cycle it shows the address, so the
  // read is combinational; a registered read would shift every fetch.
  assign data_o = store[addr_i];
endmodule // mie_pmem_model

// File: testbench.sv
// Self-checking bench for the instruction execute core.
// Assumes mie_pkg and mie_defines.svh are compiled before this file.
`timescale 1ns/1ps
`include "mie_defines.svh"
module testbench;
  import mie_pkg::*;
  localparam logic [13:0] EOR = 14'h3FFF;
  localparam logic [13:0] NOP = 14'h0000;
  localparam logic [13:0] SLP = 14'h0A00;
  localparam logic [13:0] KCK = 14'h0C00;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic wdt_timeout_i = 1'b0;
  logic wake_i = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [9:0] pm_addr_o;
  logic [13:0] pm_data_i;
  logic wdt_clear_o;
  logic halt_o;
  logic irq_enable_o;
  logic [31:0] rd;
  logic [13:0] code [$];
  logic [7:0] eacc [$];
  logic [6:0] est [$];
  int errors = 0;
  int total_checks = 0;
  int kicks = 0;

  always #4 clk_i = ~clk_i;

  always @(posedge clk_i)
    if (wdt_clear_o === 1'b1)
      kicks <= kicks + 1;

  mie_core u_mie_core (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pm_addr_o(pm_addr_o), .pm_data_i(pm_data_i),
    .wdt_timeout_i(wdt_timeout_i), .wake_i(wake_i),
    .wdt_clear_o(wdt_clear_o), .halt_o(halt_o), .irq_enable_o(irq_enable_o)
  );

  mie_pmem_model u_mie_pmem_model (.addr_i(pm_addr_o), .data_o(pm_data_i));

  // ********************
  // Helpers
  // ********************
  function automatic logic [13:0] fi(mie_op_t o, logic [7:0] v);
    return {o, 1'b0, v};
  endfunction

  function automatic logic [13:0] fr(mie_op_t o, logic [2:0] b, logic [5:0] r);
    return {o, b, r};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Entered just after a rising edge; ack is read before that edge lands.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1);
    chk(n, 2, "bus ack latency");
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic clear();
    for (int i = 0; i < 1024; i++)
      u_mie_pmem_model.store[i] = NOP;
    u_mie_pmem_model.store[10'h0F0] = 14'h2A5B;
  endtask

  task automatic restart();
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (40) @(posedge clk_i);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Whole run is under a thousand cycles; this bound only cuts a hang.
  initial
  begin
    #300000;
    $display("[ERR] %0t watchdog expired", $time);
    errors++;
    report_and_stop();
  end

  // ********************
  // Main sequence
  // ********************
  initial
  begin
    int a;
    int p;
    p = 0;
    code = '{
      fi(op_addi, 8'hFF), fi(op_addi, 8'h01), SLP, EOR,
      fi(op_addi, 8'hFF), fi(op_addi, 8'h01), fi(op_adci, 8'h34), SLP, EOR,
      fi(op_addi, 8'h34), fr(op_addr, 3'h1, 6'h07), fi(op_addi, 8'hDE),
      fr(op_adcr, 3'h1, 6'h07), fr(op_addr, 3'h0, 6'h07), SLP, EOR,
      fr(op_incsz, 3'h1, 6'h03), fi(op_addi, 8'h01),
      fr(op_decsz, 3'h1, 6'h03), fi(op_addi, 8'h10), fi(op_addi, 8'h02),
      SLP, EOR,
      fi(op_addi, 8'h05), fr(op_addr, 3'h1, 6'h09), fr(op_btsz, 3'h1, 6'h09),
      fi(op_addi, 8'h40), fr(op_btso, 3'h2, 6'h09), fi(op_addi, 8'h80),
      fr(op_btsz, 3'h0, 6'h09), fi(op_addi, 8'h01), SLP, EOR,
      fi(op_addi, 8'h08), fi(op_call_indirect_accum, 8'h00), fi(op_addi, 8'h01), SLP,
      NOP, NOP, NOP, NOP, fi(op_addi, 8'h10), fi(op_ret, 8'h00), EOR,
      fi(op_addi, 8'h06), fi(op_call_indirect_accum, 8'h00), fi(op_addi, 8'h01), SLP,
      fi(op_addi, 8'h40), NOP, fi(op_retlit, 8'h22), EOR,
      fi(op_addi, 8'h04), fi(op_jump_indirect_accum, 8'h00), fi(op_addi, 8'h40), NOP,
      SLP, EOR,
      fi(op_addi, 8'h05), fi(op_call_indirect_accum, 8'h00), SLP, NOP, NOP,
      fi(op_irq_off, 8'h00), fi(op_reti_en, 8'h00), EOR,
      fi(op_addi, 8'h3C), fi(op_fwr, 8'h04), fi(op_fwr, 8'h05),
      fi(op_swr, 8'h0F), fi(op_addi, 8'h01), fi(op_frd, 8'h05),
      fi(op_addi, 8'h01), fi(op_srd, 8'h0F), fi(op_addi, 8'h01),
      fi(op_frd, 8'h04), SLP, EOR,
      fi(op_irq_on, 8'h00), SLP, EOR,
      fi(op_addi, 8'hF0), fi(op_table, 8'h00), SLP, EOR};
    eacc = '{8'h00, 8'h35, 8'h59, 8'h03, 8'h06, 8'h19, 8'h23, 8'h04,
             8'h05, 8'h3D, 8'h00, 8'h5B};
    est = '{7'h37, 7'h30, 7'h30, 7'h30, 7'h30, 7'h30, 7'h30, 7'h30,
            7'h70, 7'h30, 7'h70, 7'h30};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int r = 0; r < eacc.size(); r++)
    begin
      clear();
      a = 0;
      while (code[p] !== EOR)
      begin
        u_mie_pmem_model.store[a] = code[p];
        a++;
        p++;
      end
      p++;
      restart();
      wb(1'b0, `MIE_OFF_ACC, 32'h0, 4'hF);
      chk(rd, {24'h0, eacc[r]}, "row acc");
      wb(1'b0, `MIE_OFF_STATUS, 32'h0, 4'hF);
      chk(rd, {25'h0, est[r]}, "row status");
      chk({31'h0, halt_o}, {31'h0, est[r][5]}, "row halt");
      chk({31'h0, irq_enable_o}, {31'h0, est[r][6]}, "row irq");
    end
    wb(1'b0, `MIE_OFF_HIBYTE, 32'h0, 4'hF);
    chk(rd, 32'h0000002A, "table high byte");
    // Fresh start with only no-operations, then bus access kinds.
    clear();
    restart();
    wb(1'b0, `MIE_OFF_STATUS, 32'h0, 4'hF);
    chk(rd, 32'h00000018, "reset status");
    wb(1'b1, `MIE_OFF_ACC, 32'h0000005A, 4'hF);
    wb(1'b1, `MIE_OFF_ACC, 32'h000000A5, 4'hE);
    wb(1'b0, `MIE_OFF_ACC, 32'h0, 4'hF);
    chk(rd, 32'h0000005A, "acc write");
    wb(1'b1, `MIE_OFF_STATUS, 32'h0000007F, 4'hF);
    wb(1'b0, `MIE_OFF_STATUS, 32'h0, 4'hF);
    chk(rd, 32'h00000018, "status read only");
    wb(1'b0, 8'h14, 32'h0, 4'hF);
    chk(rd, 32'h0, "unmapped read");
    // Sleep, wake into a watchdog kick, then a watchdog expiry.
    clear();
    u_mie_pmem_model.store[0] = SLP;
    u_mie_pmem_model.store[1] = KCK;
    restart();
    a = kicks;
    wb(1'b0, `MIE_OFF_STATUS, 32'h0, 4'hF);
    chk(rd, 32'h00000030, "sleep status");
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    chk(kicks - a, 1, "kick pulse count");
    wb(1'b0, `MIE_OFF_STATUS, 32'h0, 4'hF);
    chk(rd, 32'h00000018, "kick status");
    wdt_timeout_i <= 1'b1;
    @(posedge clk_i);
    wdt_timeout_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    wb(1'b0, `MIE_OFF_STATUS, 32'h0, 4'hF);
    chk(rd, 32'h00000008, "expiry status");
    // Halt, stall and resume by the control register, then expiry wake.
    clear();
    u_mie_pmem_model.store[0] = SLP;
    u_mie_pmem_model.store[1] = SLP;
    restart();
    chk({22'h0, pm_addr_o}, 32'h1, "halted fetch address");
    wb(1'b0, `MIE_OFF_PC, 32'h0, 4'hF);
    chk(rd, 32'h1, "halted pc");
    wb(1'b1, `MIE_OFF_CTRL, 32'h2, 4'hF);
    repeat (4) @(posedge clk_i);
    wb(1'b0, `MIE_OFF_PC, 32'h0, 4'hF);
    chk(rd, 32'h1, "stalled pc");
    wb(1'b0, `MIE_OFF_STATUS, 32'h0, 4'hF);
    chk(rd, 32'h00000010, "control wake status");
    wb(1'b1, `MIE_OFF_CTRL, 32'h1, 4'hF);
    wb(1'b0, `MIE_OFF_STATUS, 32'h0, 4'hF);
    chk(rd, 32'h00000030, "second sleep status");
    wdt_timeout_i <= 1'b1;
    @(posedge clk_i);
    wdt_timeout_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    wb(1'b0, `MIE_OFF_STATUS, 32'h0, 4'hF);
    chk(rd, 32'h00000000, "expiry wake status");
    report_and_stop();
  end
endmodule // testbench
